// ### bench/twm_checker.sv
// Port-level assertions for the two-wire master control block.
module twm_checker (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sda_oe,
   input wire logic scl_oe,
   input wire logic tx_service_flag
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence ctl_wr;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[1]
         && s_axi_awaddr == twm_pkg::A_CTL;
   endsequence
   AST_SDA_OVR: assert property (ctl_wr ##0 s_axi_wdata[14] |-> ##[1:3] sda_oe)
      else $error("data override not driven");
   AST_SCL_OVR: assert property (ctl_wr ##0 s_axi_wdata[15] |-> ##[1:3] scl_oe)
      else $error("clock override not driven");
   AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read response dropped");
   AST_AWBLK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   AST_ARBLK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while response pending");
   AST_RLAT: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr != twm_pkg::A_RXD
      |-> ##2 s_axi_rvalid) else $error("read answer late");
   AST_TXFLAG: assert property ($rose(rst_n) |-> ##[0:2] tx_service_flag)
      else $error("empty transmit buffer not flagged");
endmodule
bind twm_top twm_checker u_twm_checker (.*);

// ### bench/twm_slave_model.sv
// Target on the serial bus: acknowledges the address byte unless nak is set, else leaves data released high.
module twm_slave_model (
   input wire logic scl,
   input wire logic sda,
   input wire logic nak,
   output logic ack_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   int n = 0;
   initial ack_oe = 1'b0;
   always @(negedge sda) if (scl) n = 0;
   always @(posedge scl) n = n + 1;
   always @(negedge scl) ack_oe = (n == 8) && !nak;
endmodule

// ### bench/twm_top_tb.sv
// Self-checking bench for the two-wire master control block.
module twm_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock, rst_n, awvalid, wvalid, bready, arvalid, rready, nak;
   logic [7:0] awaddr, araddr, sh;
   logic [31:0] wdata, rdat;
   logic [1:0] rrsp, brsp;
   int fails = 0;
   int n_compared = 0;
   wire logic sda_oe, scl_oe, m_oe, tx_f, rx_f, awr, wrr, bv, arr, rv;
   wire logic [31:0] rd_d;
   wire logic [1:0] rr, br;
   wire logic sda_w = !(sda_oe || m_oe);
   wire logic scl_w = !scl_oe;
   twm_top u_twm_top (.clock(clock), .rst_n(rst_n), .ce(1'b1), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wrr), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rready), .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe), .scl_i(scl_w),
      .scl_o(), .scl_oe(scl_oe), .tx_service_flag(tx_f), .rx_service_flag(rx_f));
   twm_slave_model u_twm_slave_model (.scl(scl_w), .sda(sda_w), .nak(nak), .ack_oe(m_oe));
   always @(posedge scl_w) #1 if (u_twm_slave_model.n <= 8) sh = {sh[6:0], sda_w};
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Ready is judged at the falling edge so the rising edge that follows really takes it.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      @(posedge clock);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      forever begin
         @(negedge clock);
         ta = awvalid && awr; tw = wvalid && wrr; tb = bv; brsp = br;
         @(posedge clock);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) begin
            bready <= 1'b0;
            return;
         end
      end
   endtask
   task automatic rd(input logic [7:0] a);
      logic ta, tb;
      @(posedge clock);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      forever begin
         @(negedge clock);
         ta = arvalid && arr; tb = rv; rdat = rd_d; rrsp = rr;
         @(posedge clock);
         if (ta) arvalid <= 1'b0;
         if (tb) begin
            rready <= 1'b0;
            return;
         end
      end
   endtask
   task automatic t_ovr;
      wr(8'h00, 32'hC000);
      repeat (20) @(posedge clock);
      rd(8'h08); chk(rdat[7:6], 2'h3);
      wr(8'h00, 32'h0);
      repeat (20) @(posedge clock);
      rd(8'h08); chk(rdat[7:6], 2'h0);
      $display("override test done");
   endtask
   task automatic t_xfer(input logic d);
      nak <= !d;
      wr(8'h04, 32'h50);
      wr(8'h00, {25'h0, 1'b1, 3'h0, d, 2'h1});
      repeat (26000) @(posedge clock);
      chk(sh, {7'h50, d});
      rd(8'h08); chk(rdat[5:0], {3'h0, !d, 2'h0});
      rd(8'h00); chk(rdat[0], 1'b0);
      rd(8'h10); chk(rdat[3:0], {1'b0, d, 2'h0});
      chk(rx_f, d);
      wr(8'h08, 32'h3E); rd(8'h08); chk(rdat[5:0], 6'h0);
      $display("transfer test done");
   endtask
   task automatic t_buf;
      rd(8'h40); chk(rrsp, 2'h2);
      wr(8'h40, 32'h0); chk(brsp, 2'h2);
      wr(8'h14, 32'h11); wr(8'h14, 32'h22);
      rd(8'h10); chk(rdat[1:0], 2'h3);
      chk(tx_f, 1'b0);
      wr(8'h0C, 32'h1); rd(8'h10); chk(rdat[1:0], 2'h0);
      chk(tx_f, 1'b1);
      wr(8'h0C, 32'h0);
      $display("buffer test done");
   endtask
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial begin
      #480000;
      fails++;
      finish_test();
   end
   initial begin
      rst_n = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
      rready = 1'b0; nak = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      t_ovr();
      t_xfer(1'b0);
      t_xfer(1'b1);
      t_buf();
      finish_test();
   end
endmodule

// ### rtl/twm_pkg.sv
// Shared constants and types for the two-wire master control block.
package twm_pkg;
   localparam int CLK_NS = 8;
   localparam int FILT_NS = 50;
   localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [2:0] FILT_CNT = 3'(FILT_CYC - 1);
   localparam int TBUF_NS = 4700;
   localparam int TBUF_CYC = (TBUF_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [11:0] TBUF_CNT = 12'(TBUF_CYC - 1);
   localparam int QTR_NS = 2500;
   localparam int QTR_CYC = (QTR_NS / CLK_NS < 1) ? 1 : QTR_NS / CLK_NS;
   localparam logic [11:0] QTR_CNT = 12'(QTR_CYC - 1);
   localparam logic [7:0] A_CTL = 8'h00;
   localparam logic [7:0] A_ADR = 8'h04;
   localparam logic [7:0] A_STAT = 8'h08;
   localparam logic [7:0] A_FCTL = 8'h0C;
   localparam logic [7:0] A_FSTAT = 8'h10;
   localparam logic [7:0] A_TXD = 8'h14;
   localparam logic [7:0] A_RXD = 8'h18;
   localparam int B_EN = 0;
   localparam int B_DIR = 2;
   localparam int B_STOP = 4;
   localparam int B_RS = 5;
   localparam int B_CNT = 6;
   localparam int B_SDAO = 14;
   localparam int B_SCLO = 15;
   localparam int B_ERR = 1;
   localparam int B_SDAS = 6;
   localparam int B_SCLS = 7;
   localparam int B_BUSY = 8;
   localparam int F_TXFL = 0;
   localparam int F_RXFL = 1;
   localparam int F_TXI2 = 2;
   localparam int F_RXI2 = 3;
   localparam int F_BHD = 4;
   localparam int E_LOST = 0;
   localparam int E_ANAK = 1;
   localparam int E_DNAK = 2;
   localparam int E_RERR = 3;
   localparam int E_WERR = 4;
   localparam logic [7:0] CNT_OFF = 8'hFF;
   localparam logic [7:0] CNT_RST = 8'h00;
   localparam logic [1:0] OCC_EMPTY = 2'h0;
   localparam logic [1:0] OCC_ONE = 2'h1;
   localparam logic [1:0] OCC_FULL = 2'h3;
   localparam logic [1:0] K_ADDR = 2'h0;
   localparam logic [1:0] K_TX = 2'h1;
   localparam logic [1:0] K_RX = 2'h2;
   typedef enum logic [2:0] {ST_IDLE, ST_START, ST_RSTART, ST_BIT, ST_STOP} twm_state_t;
endpackage

// ### rtl/twm_top.sv
// Two-wire master transfer control, status and buffer control with AXI4-Lite registers.
// Overview of operation
// RULE1: Stop request ends transfer at next byte boundary.
// RULE2: Repeat start restarts when count reaches zero.
// RULE3: No restart after error; enable stays on restart.
// RULE4: Eight-bit count decrements per byte; zero ends.
// RULE5: Count all ones runs until stop request.
// RULE6: Data override pulls data line low.
// RULE7: Clock override pulls clock line low.
// RULE8: Seven-bit address sent with direction bit appended.
// RULE9: Progress bit high only during master transfer.
// RULE10: Lost arbitration aborts, sticky, write one clears.
// RULE11: Address NAK aborts, sticky, write one clears.
// RULE12: Data NAK aborts, sticky, write one clears.
// RULE13: Empty transmit buffer when needed aborts, flags.
// RULE14: Full receive buffer at byte end aborts, flags.
// RULE15: Sense bits show filtered lines, one when low.
// RULE16: Busy sets on start, clears after bus-free time.
// RULE17: Transmit flush empties buffer while set.
// RULE18: Receive flush empties buffer, looks full inside.
// RULE19: Transmit service flag threshold by length bit.
// RULE20: Receive service flag threshold by length bit.
// RULE21: Buffer accesses stall unless hang disabled.
// RULE22: Enable starts when bus idle, self clears.
// RULE23: Direction bit picks transmit or receive.
// RULE24: Occupancy codes empty, one byte, full.
// RULE25: Address shifted most significant bit first.
module twm_top (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   output logic tx_service_flag,
   output logic rx_service_flag
);

   function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[8*b +: 8] = n[8*b +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return a == twm_pkg::A_CTL || a == twm_pkg::A_ADR || a == twm_pkg::A_STAT ||
             a == twm_pkg::A_FCTL || a == twm_pkg::A_FSTAT || a == twm_pkg::A_TXD ||
             a == twm_pkg::A_RXD;
   endfunction

   function automatic logic [1:0] occ(input logic [1:0] c);
      return (c == 2'h0) ? twm_pkg::OCC_EMPTY :
             (c == 2'h1) ? twm_pkg::OCC_ONE : twm_pkg::OCC_FULL;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////
   logic [1:0] in_s1_q, in_s2_q, flt_q, flt_prev_q;
   logic [2:0] flt_cnt_q [2];
   logic sda_f, scl_f, start_det, stop_det;
   logic busy_q, tbuf_run_q;
   logic [11:0] tbuf_q;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         in_s1_q <= 2'h3;
         in_s2_q <= 2'h3;
      end else if (ce) begin
         in_s1_q <= {scl_i, sda_i};
         in_s2_q <= in_s1_q;
      end
   end

   // A level must hold for the filter time before it is believed.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         flt_q <= 2'h3;
         flt_prev_q <= 2'h3;
         flt_cnt_q[0] <= 3'h0;
         flt_cnt_q[1] <= 3'h0;
      end else if (ce) begin
         flt_prev_q <= flt_q;
         for (int i = 0; i < 2; i++) begin
            if (in_s2_q[i] == flt_q[i]) begin
               flt_cnt_q[i] <= 3'h0;
            end else if (flt_cnt_q[i] == twm_pkg::FILT_CNT) begin
               flt_q[i] <= in_s2_q[i]; // RULE15
               flt_cnt_q[i] <= 3'h0;
            end else begin
               flt_cnt_q[i] <= flt_cnt_q[i] + 3'h1;
            end
         end
      end
   end

   assign sda_f = flt_q[0];
   assign scl_f = flt_q[1];
   assign start_det = scl_f & flt_prev_q[1] & flt_prev_q[0] & ~sda_f;
   assign stop_det = scl_f & flt_prev_q[1] & ~flt_prev_q[0] & sda_f;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
         tbuf_run_q <= 1'b0;
         tbuf_q <= 12'h000;
      end else if (ce) begin
         if (start_det) begin
            busy_q <= 1'b1; // RULE16
            tbuf_run_q <= 1'b0;
         end else if (stop_det) begin
            tbuf_run_q <= 1'b1;
            tbuf_q <= twm_pkg::TBUF_CNT;
         end else if (tbuf_run_q) begin
            if (!(sda_f && scl_f)) begin
               tbuf_q <= twm_pkg::TBUF_CNT;
            end else if (tbuf_q == 12'h000) begin
               busy_q <= 1'b0; // RULE16
               tbuf_run_q <= 1'b0;
            end else begin
               tbuf_q <= tbuf_q - 12'h001;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   logic aw_v_q, w_v_q, bvalid_q, ar_v_q, rvalid_q;
   logic [7:0] aw_a_q, ar_a_q;
   logic [31:0] wd_q, rdata_q, rd_mux, ctl_w;
   logic [3:0] ws_q;
   logic [1:0] bresp_q, rresp_q;
   logic wr_go, rd_go, wr_ctl, tx_push, rx_pop, hang_off;
   logic en_q, dir_q, stop_q, rs_q, sdao_q, sclo_q;
   logic [7:0] cnt_q;
   logic [6:0] tadr_q;
   logic [4:0] err_q, fctl_q;
   logic [15:0] ctl_rd;
   logic [7:0] txm_q [2];
   logic [7:0] rxm_q [2];
   logic tx_rp_q, tx_wp_q, rx_rp_q, rx_wp_q;
   logic [1:0] tx_cnt_q, rx_cnt_q;
   logic tx_empty_m, rx_full_m;
   logic evt_done_q, evt_dec_q, tx_pop_q, rx_push_q;
   logic [4:0] err_set_q;
   logic [7:0] rxb_q;
   twm_pkg::twm_state_t st_q;

   assign hang_off = fctl_q[twm_pkg::F_BHD];
   assign s_axi_awready = ~aw_v_q & ~bvalid_q;
   assign s_axi_wready = ~w_v_q & ~bvalid_q;
   assign s_axi_arready = ~ar_v_q & ~rvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;
   // A transmit-data write waits for a free slot, a receive-data read for a byte.
   assign wr_go = aw_v_q & w_v_q & ~bvalid_q &
                  (aw_a_q != twm_pkg::A_TXD || tx_cnt_q != 2'h2 || hang_off); // RULE21
   assign rd_go = ar_v_q & ~rvalid_q &
                  (ar_a_q != twm_pkg::A_RXD || rx_cnt_q != 2'h0 || hang_off); // RULE21
   assign wr_ctl = wr_go && aw_a_q == twm_pkg::A_CTL;
   assign tx_push = wr_go && aw_a_q == twm_pkg::A_TXD && tx_cnt_q != 2'h2;
   assign rx_pop = rd_go && ar_a_q == twm_pkg::A_RXD && rx_cnt_q != 2'h0;
   assign ctl_rd = {sclo_q, sdao_q, cnt_q, rs_q, stop_q, 1'b0, dir_q, 1'b0, en_q};
   assign ctl_w = wmerge({16'h0000, ctl_rd}, wd_q, ws_q);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         aw_v_q <= 1'b0;
         w_v_q <= 1'b0;
         bvalid_q <= 1'b0;
         ar_v_q <= 1'b0;
         rvalid_q <= 1'b0;
         aw_a_q <= 8'h00;
         ar_a_q <= 8'h00;
         wd_q <= 32'h00000000;
         ws_q <= 4'h0;
         rdata_q <= 32'h00000000;
         bresp_q <= 2'h0;
         rresp_q <= 2'h0;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_v_q <= 1'b1;
            aw_a_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_v_q <= 1'b1;
            wd_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_v_q <= 1'b0;
            w_v_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= mapped(aw_a_q) ? 2'h0 : 2'h2;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            ar_v_q <= 1'b1;
            ar_a_q <= s_axi_araddr;
         end
         if (rd_go) begin
            ar_v_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= mapped(ar_a_q) ? 2'h0 : 2'h2;
         end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   always_comb begin
      rd_mux = 32'h00000000;
      case (ar_a_q)
         twm_pkg::A_CTL: rd_mux = {16'h0000, ctl_rd};
         twm_pkg::A_ADR: rd_mux = {25'h0000000, tadr_q};
         twm_pkg::A_STAT: rd_mux = {23'h000000, busy_q, ~scl_f, ~sda_f, err_q,
                                    st_q != twm_pkg::ST_IDLE}; // RULE9 RULE15
         twm_pkg::A_FCTL: rd_mux = {27'h0000000, fctl_q};
         twm_pkg::A_FSTAT: rd_mux = {28'h0000000, occ(rx_cnt_q), occ(tx_cnt_q)}; // RULE24
         twm_pkg::A_RXD: rd_mux = {24'h000000, rxm_q[rx_rp_q]};
         default: rd_mux = 32'h00000000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         en_q <= 1'b0;
         dir_q <= 1'b0;
         stop_q <= 1'b0;
         rs_q <= 1'b0;
         sdao_q <= 1'b0;
         sclo_q <= 1'b0;
         cnt_q <= twm_pkg::CNT_RST;
      end else if (ce) begin
         if (wr_ctl) begin
            en_q <= ctl_w[twm_pkg::B_EN];
            dir_q <= ctl_w[twm_pkg::B_DIR];
            stop_q <= ctl_w[twm_pkg::B_STOP];
            rs_q <= ctl_w[twm_pkg::B_RS];
            cnt_q <= ctl_w[twm_pkg::B_CNT +: 8];
            sdao_q <= ctl_w[twm_pkg::B_SDAO];
            sclo_q <= ctl_w[twm_pkg::B_SCLO];
         end else if (evt_dec_q && cnt_q != twm_pkg::CNT_OFF && cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01; // RULE4 RULE5
         end
         if (evt_done_q) begin
            en_q <= 1'b0; // RULE22
            stop_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         tadr_q <= 7'h00;
         fctl_q <= 5'h00;
         err_q <= 5'h00;
      end else if (ce) begin
         if (wr_go && aw_a_q == twm_pkg::A_ADR) begin
            tadr_q <= 7'(wmerge({25'h0000000, tadr_q}, wd_q, ws_q)); // RULE8
         end
         if (wr_go && aw_a_q == twm_pkg::A_FCTL) begin
            fctl_q <= 5'(wmerge({27'h0000000, fctl_q}, wd_q, ws_q));
         end
         // A new error in the clearing cycle survives the clear.
         if (wr_go && aw_a_q == twm_pkg::A_STAT && ws_q[0]) begin
            err_q <= (err_q & ~wd_q[twm_pkg::B_ERR +: 5]) | err_set_q; // RULE10 RULE11 RULE12
         end else begin
            err_q <= err_q | err_set_q; // RULE13 RULE14
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   assign tx_empty_m = tx_cnt_q == 2'h0 || fctl_q[twm_pkg::F_TXFL]; // RULE17
   assign rx_full_m = rx_cnt_q == 2'h2 || fctl_q[twm_pkg::F_RXFL]; // RULE18

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         tx_rp_q <= 1'b0;
         tx_wp_q <= 1'b0;
         tx_cnt_q <= 2'h0;
         txm_q[0] <= 8'h00;
         txm_q[1] <= 8'h00;
      end else if (ce) begin
         if (fctl_q[twm_pkg::F_TXFL]) begin
            tx_rp_q <= 1'b0; // RULE17
            tx_wp_q <= 1'b0;
            tx_cnt_q <= 2'h0;
         end else begin
            if (tx_push) begin
               txm_q[tx_wp_q] <= wd_q[7:0];
               tx_wp_q <= ~tx_wp_q;
            end
            if (tx_pop_q) begin
               tx_rp_q <= ~tx_rp_q;
            end
            tx_cnt_q <= tx_cnt_q + {1'b0, tx_push} - {1'b0, tx_pop_q};
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rx_rp_q <= 1'b0;
         rx_wp_q <= 1'b0;
         rx_cnt_q <= 2'h0;
         rxm_q[0] <= 8'h00;
         rxm_q[1] <= 8'h00;
      end else if (ce) begin
         if (fctl_q[twm_pkg::F_RXFL]) begin
            rx_rp_q <= 1'b0; // RULE18
            rx_wp_q <= 1'b0;
            rx_cnt_q <= 2'h0;
         end else begin
            if (rx_push_q) begin
               rxm_q[rx_wp_q] <= rxb_q;
               rx_wp_q <= ~rx_wp_q;
            end
            if (rx_pop) begin
               rx_rp_q <= ~rx_rp_q;
            end
            rx_cnt_q <= rx_cnt_q + {1'b0, rx_push_q} - {1'b0, rx_pop};
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         tx_service_flag <= 1'b0;
         rx_service_flag <= 1'b0;
      end else if (ce) begin
         tx_service_flag <= fctl_q[twm_pkg::F_TXI2] ? occ(tx_cnt_q) == twm_pkg::OCC_EMPTY :
                            occ(tx_cnt_q) != twm_pkg::OCC_FULL; // RULE19
         rx_service_flag <= fctl_q[twm_pkg::F_RXI2] ? occ(rx_cnt_q) == twm_pkg::OCC_FULL :
                            occ(rx_cnt_q) != twm_pkg::OCC_EMPTY; // RULE20
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   logic [1:0] ph_q, kind_q;
   logic [11:0] qt_q;
   logic [3:0] idx_q;
   logic [7:0] sh_q;
   logic sda_low_q, scl_low_q, outbit, done;

   // In receive the last byte is answered with a NAK so the slave lets go.
   assign outbit = (kind_q == twm_pkg::K_RX) ?
                   (idx_q == 4'h8 ? (stop_q || cnt_q == 8'h01) : 1'b1) :
                   (idx_q == 4'h8 ? 1'b1 : sh_q[7]);
   assign done = cnt_q == 8'h00 || stop_q; // RULE1 RULE4 RULE5

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st_q <= twm_pkg::ST_IDLE;
         ph_q <= 2'h0;
         qt_q <= twm_pkg::QTR_CNT;
         idx_q <= 4'h0;
         sh_q <= 8'h00;
         kind_q <= twm_pkg::K_ADDR;
         sda_low_q <= 1'b0;
         scl_low_q <= 1'b0;
         evt_done_q <= 1'b0;
         evt_dec_q <= 1'b0;
         err_set_q <= 5'h00;
         tx_pop_q <= 1'b0;
         rx_push_q <= 1'b0;
         rxb_q <= 8'h00;
      end else if (ce) begin
         evt_done_q <= 1'b0;
         evt_dec_q <= 1'b0;
         err_set_q <= 5'h00;
         tx_pop_q <= 1'b0;
         rx_push_q <= 1'b0;
         if (st_q != twm_pkg::ST_IDLE && !en_q) begin
            st_q <= twm_pkg::ST_IDLE;
            sda_low_q <= 1'b0;
            scl_low_q <= 1'b0;
         end else if (st_q == twm_pkg::ST_IDLE) begin
            qt_q <= twm_pkg::QTR_CNT;
            ph_q <= 2'h0;
            if (en_q && !busy_q && sda_f && scl_f) begin
               st_q <= twm_pkg::ST_START; // RULE22
            end
         end else if (qt_q != 12'h000) begin
            qt_q <= qt_q - 12'h001;
         end else begin
            qt_q <= twm_pkg::QTR_CNT;
            ph_q <= ph_q + 2'h1;
            case (st_q)
               twm_pkg::ST_START, twm_pkg::ST_RSTART: begin
                  case (ph_q)
                     2'h0: begin
                        sda_low_q <= st_q == twm_pkg::ST_START;
                     end
                     2'h1: begin
                        scl_low_q <= st_q == twm_pkg::ST_START;
                     end
                     2'h2: begin
                        if (st_q == twm_pkg::ST_RSTART) begin
                           if (scl_f) begin
                              sda_low_q <= 1'b1; // RULE2
                           end else begin
                              ph_q <= ph_q;
                           end
                        end
                     end
                     default: begin
                        scl_low_q <= 1'b1;
                        sh_q <= {tadr_q, dir_q}; // RULE8 RULE23 RULE25
                        kind_q <= twm_pkg::K_ADDR;
                        idx_q <= 4'h0;
                        st_q <= twm_pkg::ST_BIT;
                     end
                  endcase
               end
               twm_pkg::ST_BIT: begin
                  case (ph_q)
                     2'h0: begin
                        if (idx_q == 4'h8 && kind_q == twm_pkg::K_RX && rx_full_m) begin
                           err_set_q[twm_pkg::E_WERR] <= 1'b1; // RULE14 RULE18
                           st_q <= twm_pkg::ST_STOP;
                           ph_q <= 2'h0;
                        end else begin
                           sda_low_q <= ~outbit;
                        end
                     end
                     2'h1: begin
                        scl_low_q <= 1'b0;
                     end
                     2'h2: begin
                        if (!scl_f) begin
                           ph_q <= ph_q;
                        end else if (idx_q != 4'h8) begin
                           if (kind_q == twm_pkg::K_RX) begin
                              sh_q <= {sh_q[6:0], sda_f};
                           end else if (outbit && !sda_f) begin
                              err_set_q[twm_pkg::E_LOST] <= 1'b1; // RULE10
                              evt_done_q <= 1'b1;
                              st_q <= twm_pkg::ST_IDLE;
                              sda_low_q <= 1'b0;
                              scl_low_q <= 1'b0;
                           end
                        end else if (kind_q == twm_pkg::K_RX) begin
                           rx_push_q <= 1'b1;
                           rxb_q <= sh_q;
                           evt_dec_q <= 1'b1;
                        end else if (sda_f) begin
                           err_set_q[twm_pkg::E_ANAK] <= kind_q == twm_pkg::K_ADDR; // RULE11
                           err_set_q[twm_pkg::E_DNAK] <= kind_q == twm_pkg::K_TX; // RULE12
                           st_q <= twm_pkg::ST_STOP;
                           ph_q <= 2'h0;
                        end else if (kind_q == twm_pkg::K_TX) begin
                           evt_dec_q <= 1'b1; // RULE4
                        end
                     end
                     default: begin
                        scl_low_q <= 1'b1;
                        idx_q <= 4'h0;
                        if (idx_q != 4'h8) begin
                           idx_q <= idx_q + 4'h1;
                           if (kind_q != twm_pkg::K_RX) begin
                              sh_q <= {sh_q[6:0], 1'b0}; // RULE25
                           end
                        end else if (done) begin
                           // Error paths never reach here, so a restart follows only clean ends.
                           st_q <= rs_q ? twm_pkg::ST_RSTART : twm_pkg::ST_STOP; // RULE2 RULE3
                        end else if (kind_q == twm_pkg::K_RX || dir_q) begin
                           kind_q <= twm_pkg::K_RX; // RULE23
                        end else if (tx_empty_m) begin
                           err_set_q[twm_pkg::E_RERR] <= 1'b1; // RULE13 RULE17
                           st_q <= twm_pkg::ST_STOP;
                        end else begin
                           sh_q <= txm_q[tx_rp_q];
                           tx_pop_q <= 1'b1;
                           kind_q <= twm_pkg::K_TX;
                        end
                     end
                  endcase
               end
               twm_pkg::ST_STOP: begin
                  case (ph_q)
                     2'h0: scl_low_q <= 1'b1;
                     2'h1: sda_low_q <= 1'b1;
                     2'h2: scl_low_q <= 1'b0;
                     default: begin
                        if (scl_f) begin
                           sda_low_q <= 1'b0;
                           evt_done_q <= 1'b1; // RULE22
                           st_q <= twm_pkg::ST_IDLE;
                        end else begin
                           ph_q <= ph_q;
                        end
                     end
                  endcase
               end
               default: st_q <= twm_pkg::ST_IDLE;
            endcase
         end
      end
   end

   assign sda_o = 1'b0;
   assign scl_o = 1'b0;
   assign sda_oe = sda_low_q | sdao_q; // RULE6
   assign scl_oe = scl_low_q | sclo_q; // RULE7

endmodule
